// file: adc_ctl_pkg.sv
// shared constants, field positions and carrier types of the converter control
package adc_ctl_pkg;

    localparam int RES_W = 10;
    localparam int PER_W = 11;

    // control register one fields
    localparam int C1_START = 7;
    localparam int C1_MODE_HI = 6;
    localparam int C1_MODE_LO = 5;
    localparam int C1_IN_DIS = 4;
    localparam int C1_CHAN_HI = 3;
    localparam int C1_CHAN_LO = 0;
    // control register two fields
    localparam int C2_REF_ON = 5;
    localparam int C2_SPEED_HI = 3;
    localparam int C2_SPEED_LO = 1;
    localparam logic [7:0] C2_READ_MASK = 8'h3F;
    // result low / status register fields
    localparam int ST_DONE = 5;
    localparam int ST_BUSY = 4;

    localparam logic [7:0] CTL1_INIT = 8'h00;
    localparam logic [7:0] CTL2_INIT = 8'h00;
    localparam logic [9:0] RESULT_INIT = 10'h000;

    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_REPEAT = 2'h3;

    // conversion periods in high_freq_clock cycles (MCLK is that clock)
    localparam logic [10:0] PER_39 = 11'h027;
    localparam logic [10:0] PER_78 = 11'h04E;
    localparam logic [10:0] PER_156 = 11'h09C;
    localparam logic [10:0] PER_312 = 11'h138;
    localparam logic [10:0] PER_624 = 11'h270;
    localparam logic [10:0] PER_1248 = 11'h4E0;
    localparam logic [9:0] SAR_FIRST = 10'h200;
    localparam logic [3:0] SAR_TOP_BIT = 4'h9;

    typedef struct packed {
        logic wr;
        logic [7:0] data;
    } reg_wr_t;

    typedef enum logic [1:0] {SAR_IDLE, SAR_DECIDE, SAR_SETTLE} sar_phase_t;

    typedef struct packed {
        sar_phase_t phase;
        logic done;
        logic [9:0] code;
        logic [9:0] result;
        logic [3:0] idx;
        logic [6:0] step;
        logic [10:0] elapsed;
        logic [10:0] per;
    } sar_state_t;

    typedef struct packed {
        logic [7:0] ctl1;
        logic [7:0] ctl2;
        logic [9:0] result;
        logic done;
        logic busy;
        logic irq;
        logic start;
        logic ref_on;
    } ctl_state_t;

    // reserved speed codes give zero, which refuses the start
    function automatic logic [10:0] conv_period(input logic [2:0] code);
        case (code)
            3'h0: conv_period = PER_39;
            3'h2: conv_period = PER_78;
            3'h3: conv_period = PER_156;
            3'h4: conv_period = PER_312;
            3'h5: conv_period = PER_624;
            3'h6: conv_period = PER_1248;
            default: conv_period = 11'h000;
        endcase
    endfunction

endpackage

// file: adc_sequencer_standby_control.sv
// converter control: registers, start and repeat sequencing, standby handling
`timescale 1ns/10ps
`default_nettype none

// Contract
// - standby entry abandons a running conversion at once
// - standby entry returns both control registers to their initial values
// - standby entry wipes the stored result and the done flag
// - after standby the converter stays idle until software starts again
// - the reference is disconnected throughout standby
// - each conversion yields a 10-bit code of the sampled level
// - low 2 result bits in low/status register, upper 8 in high register
// - setting bit 7 of control register one requests a conversion start
// - writing 00100011B to control register one selects channel 3
// - writing 11011000B to control register two selects 312 clock periods
// - completion raises the interrupt request for latch fifteen
// - the done flag is readable at any time for polling
// - completion stores result, sets done flag and raises interrupt together
// - the start bit clears itself once the conversion has begun
// - the busy flag clears on standby entry as well as at completion in single mode
module adc_sequencer_standby_control (
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic STANDBY,
    input wire adc_ctl_pkg::reg_wr_t CONV_CONTROL_ONE_WR,
    input wire adc_ctl_pkg::reg_wr_t CONV_CONTROL_TWO_WR,
    input wire logic RESULT_HIGH_RD,
    input wire logic COMP_IN,
    output logic [7:0] CONV_CONTROL_ONE,
    output logic [7:0] CONV_CONTROL_TWO,
    output logic [7:0] RESULT_HIGH_REG,
    output logic [7:0] RESULT_LOW_STATUS_REG,
    output logic CONV_DONE_IRQ,
    output logic [3:0] CHAN_SELECT,
    output logic INPUT_DISABLE,
    output logic REF_CONNECT,
    output logic [9:0] DAC_TRIAL
);

    adc_ctl_pkg::ctl_state_t s_r;
    adc_ctl_pkg::ctl_state_t s_nxt;
    logic [1:0] mode;
    logic [10:0] period;
    logic abort;
    logic sar_done;
    logic [9:0] sar_result;

    assign mode = s_r.ctl1[adc_ctl_pkg::C1_MODE_HI:adc_ctl_pkg::C1_MODE_LO];
    assign period = adc_ctl_pkg::conv_period(
        s_r.ctl2[adc_ctl_pkg::C2_SPEED_HI:adc_ctl_pkg::C2_SPEED_LO]);
    assign abort = STANDBY || (mode == adc_ctl_pkg::MODE_OFF);

    sar_engine u_sar (
        .clk(MCLK),
        .rst_n(RESET_N),
        .start(s_r.start),
        .abort(abort),
        .period(period),
        .comp(COMP_IN),
        .trial(DAC_TRIAL),
        .result(sar_result),
        .done(sar_done)
    );

    assign CONV_CONTROL_ONE = s_r.ctl1;
    // upper two bits of control register two carry nothing and read as zero
    assign CONV_CONTROL_TWO = s_r.ctl2 & adc_ctl_pkg::C2_READ_MASK;
    assign CHAN_SELECT = s_r.ctl1[adc_ctl_pkg::C1_CHAN_HI:adc_ctl_pkg::C1_CHAN_LO];
    assign INPUT_DISABLE = s_r.ctl1[adc_ctl_pkg::C1_IN_DIS];
    assign CONV_DONE_IRQ = s_r.irq;
    assign REF_CONNECT = s_r.ref_on;
    assign RESULT_HIGH_REG = s_r.result[9:2];
    // done flag at bit 5, readable always
    assign RESULT_LOW_STATUS_REG = {s_r.result[1:0], s_r.done, s_r.busy, 4'h0};

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.irq = 1'b0;
        s_nxt.start = 1'b0;
        if (STANDBY)
        begin
            s_nxt.ctl1 = adc_ctl_pkg::CTL1_INIT;
            s_nxt.ctl2 = adc_ctl_pkg::CTL2_INIT;
            s_nxt.result = adc_ctl_pkg::RESULT_INIT;
            s_nxt.done = 1'b0;
            s_nxt.busy = 1'b0;
            s_nxt.ref_on = 1'b0;
        end
        else
        begin
            if (RESULT_HIGH_RD)
                s_nxt.done = 1'b0;
            if (mode == adc_ctl_pkg::MODE_OFF)
                s_nxt.busy = 1'b0;
            else if (sar_done)
            begin
                // store, flag and interrupt in one edge
                s_nxt.result = sar_result;
                s_nxt.done = 1'b1;
                s_nxt.irq = 1'b1;
                s_nxt.busy = 1'b0;
                if (mode == adc_ctl_pkg::MODE_REPEAT)
                begin
                    s_nxt.start = 1'b1;
                    s_nxt.busy = 1'b1;
                end
            end
            else if (s_r.ctl1[adc_ctl_pkg::C1_START] && !s_r.busy && period != 11'h000)
            begin
                s_nxt.start = 1'b1;
                s_nxt.busy = 1'b1;
                // a restart before the result is read drops the old done flag
                s_nxt.done = 1'b0;
                s_nxt.ctl1[adc_ctl_pkg::C1_START] = 1'b0;
            end
            // a write in the same cycle wins over the self-clear
            if (CONV_CONTROL_ONE_WR.wr)
                s_nxt.ctl1 = CONV_CONTROL_ONE_WR.data;
            if (CONV_CONTROL_TWO_WR.wr)
                s_nxt.ctl2 = CONV_CONTROL_TWO_WR.data;
            s_nxt.ref_on = s_nxt.ctl2[adc_ctl_pkg::C2_REF_ON] || s_nxt.busy;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (!RESET_N)
        begin
            s_r <= '0;
            s_r.ctl1 <= adc_ctl_pkg::CTL1_INIT;
            s_r.ctl2 <= adc_ctl_pkg::CTL2_INIT;
        end
        else
            s_r <= s_nxt;
    end

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESET_N);

    sequence s_standby_entry;
        STANDBY;
    endsequence

    sequence s_start_taken;
        !STANDBY && mode != adc_ctl_pkg::MODE_OFF && !sar_done && !s_r.busy
            && s_r.ctl1[adc_ctl_pkg::C1_START] && period != 11'h000 && !CONV_CONTROL_ONE_WR.wr;
    endsequence

    sequence s_completion;
        sar_done && !STANDBY && mode != adc_ctl_pkg::MODE_OFF;
    endsequence

    a_standby_abort: assert property (
        s_standby_entry |=> !s_r.busy && !REF_CONNECT ##1 !sar_done)
        else $error("conversion kept running in standby");

    a_standby_init: assert property (
        s_standby_entry |=> CONV_CONTROL_ONE == adc_ctl_pkg::CTL1_INIT
            && s_r.ctl2 == adc_ctl_pkg::CTL2_INIT)
        else $error("control registers not initialised by standby");

    a_standby_wipe: assert property (
        s_standby_entry |=> RESULT_HIGH_REG == 8'h00 && RESULT_LOW_STATUS_REG == 8'h00)
        else $error("result survived standby");

    a_no_resume: assert property (
        $fell(STANDBY) && !CONV_CONTROL_ONE_WR.wr |-> !s_r.busy [*2])
        else $error("conversion resumed after standby by itself");

    a_ref_detach: assert property (
        STANDBY [*2] |-> !REF_CONNECT)
        else $error("reference connected during standby");

    a_result_split: assert property (
        s_completion |=> RESULT_HIGH_REG == $past(sar_result[9:2])
            && RESULT_LOW_STATUS_REG[7:6] == $past(sar_result[1:0]))
        else $error("result bits placed wrongly");

    a_start_request: assert property (
        s_start_taken |=> s_r.busy && !CONV_CONTROL_ONE[adc_ctl_pkg::C1_START]
            ##1 DAC_TRIAL == adc_ctl_pkg::SAR_FIRST)
        else $error("start bit did not start or did not clear");

    a_done_together: assert property (
        s_completion |=> CONV_DONE_IRQ && RESULT_LOW_STATUS_REG[5] ##1 !CONV_DONE_IRQ)
        else $error("done flag and interrupt not raised together");

    a_done_held: assert property (
        RESULT_LOW_STATUS_REG[5] && !RESULT_HIGH_RD && !STANDBY && !$rose(s_r.start)
            && !s_r.ctl1[adc_ctl_pkg::C1_START] |=> RESULT_LOW_STATUS_REG[5])
        else $error("done flag lost before it was read");

    a_channel_three: assert property (
        !STANDBY && CONV_CONTROL_ONE_WR.wr && CONV_CONTROL_ONE_WR.data == 8'h23
            |=> CHAN_SELECT == 4'h3 && mode == adc_ctl_pkg::MODE_SINGLE)
        else $error("channel three not selected");

    a_period_312: assert property (
        !STANDBY && CONV_CONTROL_TWO_WR.wr && CONV_CONTROL_TWO_WR.data == 8'hD8
            |=> period == 11'h138)
        else $error("312 cycle period not selected");

    a_busy_clear: assert property (
        (s_completion and mode == adc_ctl_pkg::MODE_SINGLE) |=> !RESULT_LOW_STATUS_REG[4])
        else $error("busy flag not cleared at completion");

endmodule

`default_nettype wire

// file: analog_source.sv
// analog input model: comparator of the sampled level against the trial code
`timescale 1ns/10ps
`default_nettype none

module analog_source (
    input wire logic [9:0] level,
    input wire logic [9:0] trial,
    output logic comp
);
    // ideal comparator, so a correct search must land exactly on the level
    assign comp = (level >= trial);
endmodule

`default_nettype wire

// file: sar_engine.sv
// successive-approximation engine: ten bit decisions paced over one period
`timescale 1ns/10ps
`default_nettype none

module sar_engine (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic abort,
    input wire logic [10:0] period,
    input wire logic comp,
    output logic [9:0] trial,
    output logic [9:0] result,
    output logic done
);

    adc_ctl_pkg::sar_state_t s_r;
    adc_ctl_pkg::sar_state_t s_nxt;

    assign trial = s_r.code;
    assign result = s_r.result;
    assign done = s_r.done;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        case (s_r.phase)
            adc_ctl_pkg::SAR_IDLE:
            begin
                if (start)
                begin
                    s_nxt.phase = adc_ctl_pkg::SAR_DECIDE;
                    s_nxt.code = adc_ctl_pkg::SAR_FIRST;
                    s_nxt.idx = adc_ctl_pkg::SAR_TOP_BIT;
                    s_nxt.per = period;
                    s_nxt.step = period[10:4] - 7'h01;
                    s_nxt.elapsed = 11'h000;
                end
            end
            adc_ctl_pkg::SAR_DECIDE:
            begin
                s_nxt.elapsed = s_r.elapsed + 11'h001;
                if (s_r.step == 7'h00)
                begin
                    s_nxt.step = s_r.per[10:4] - 7'h01;
                    // comp high means the input is at or above the trial level
                    if (!comp)
                        s_nxt.code = s_r.code & ~(10'h001 << s_r.idx);
                    if (s_r.idx == 4'h0)
                        s_nxt.phase = adc_ctl_pkg::SAR_SETTLE;
                    else
                    begin
                        s_nxt.idx = s_r.idx - 4'h1;
                        s_nxt.code = s_nxt.code | (10'h001 << (s_r.idx - 4'h1));
                    end
                end
                else
                    s_nxt.step = s_r.step - 7'h01;
            end
            adc_ctl_pkg::SAR_SETTLE:
            begin
                s_nxt.elapsed = s_r.elapsed + 11'h001;
                if (s_r.elapsed >= s_r.per - 11'h002)
                begin
                    s_nxt.phase = adc_ctl_pkg::SAR_IDLE;
                    s_nxt.result = s_r.code;
                    s_nxt.done = 1'b1;
                end
            end
            default: s_nxt.phase = adc_ctl_pkg::SAR_IDLE;
        endcase
        if (abort)
            s_nxt.phase = adc_ctl_pkg::SAR_IDLE;
        if (abort)
            s_nxt.done = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

endmodule

`default_nettype wire

// file: testbench.sv
// self-checking bench of the converter control block
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic mclk;
    logic reset_n;
    logic standby;
    logic rd;
    logic comp;
    logic [9:0] level;
    adc_ctl_pkg::reg_wr_t w1;
    adc_ctl_pkg::reg_wr_t w2;
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [7:0] rhi;
    logic [7:0] rlo;
    logic irq;
    logic [3:0] chan;
    logic in_dis;
    logic ref_con;
    logic [9:0] trial;
    int n_fail;
    int num_checks;
    int cyc;

    adc_sequencer_standby_control u_dut (
        .MCLK(mclk),
        .RESET_N(reset_n),
        .STANDBY(standby),
        .CONV_CONTROL_ONE_WR(w1),
        .CONV_CONTROL_TWO_WR(w2),
        .RESULT_HIGH_RD(rd),
        .COMP_IN(comp),
        .CONV_CONTROL_ONE(ctl1),
        .CONV_CONTROL_TWO(ctl2),
        .RESULT_HIGH_REG(rhi),
        .RESULT_LOW_STATUS_REG(rlo),
        .CONV_DONE_IRQ(irq),
        .CHAN_SELECT(chan),
        .INPUT_DISABLE(in_dis),
        .REF_CONNECT(ref_con),
        .DAC_TRIAL(trial)
    );

    analog_source u_src (
        .level(level),
        .trial(trial),
        .comp(comp)
    );

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            n_fail++;
            complete_run();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wr(input logic which, input logic [7:0] d);
        step(1);
        if (which)
            w2 = '{wr: 1'b1, data: d};
        else
            w1 = '{wr: 1'b1, data: d};
        step(1);
        w1.wr = 1'b0;
        w2.wr = 1'b0;
    endtask

    // bounded wait; n counts edges from the call to the interrupt pulse
    task automatic wait_irq(output int n);
        n = 0;
        while (irq !== 1'b1 && n < 2000)
        begin
            step(1);
            n++;
        end
        chk("irq seen", 16'h0001, {15'h0000, irq});
    endtask

    task automatic chk_result(input logic [9:0] exp);
        chk("result", {6'h00, exp}, {6'h00, rhi, rlo[7:6]});
    endtask

    task automatic single_conv();
        int n;
        level = 10'h2B5;
        wr(1'b1, 8'hD8);
        wr(1'b0, 8'h23);
        chk("ctl1", 16'h0023, {8'h00, ctl1});
        chk("chan", 16'h0003, {12'h000, chan});
        chk("ctl2", 16'h0018, {8'h00, ctl2});
        wr(1'b0, 8'hA3);
        step(1);
        chk("start clr", 16'h0023, {8'h00, ctl1});
        chk("busy", 16'h0001, {15'h0000, rlo[4]});
        chk("ref", 16'h0001, {15'h0000, ref_con});
        wait_irq(n);
        chk("period", 16'h0001, {15'h0000, (n >= 311 && n <= 316)});
        chk_result(10'h2B5);
        chk("done", 16'h0001, {15'h0000, rlo[5]});
        chk("busy end", 16'h0000, {15'h0000, rlo[4]});
        chk("ref idle", 16'h0000, {15'h0000, ref_con});
        step(1);
        chk("irq pulse", 16'h0000, {15'h0000, irq});
        // software view: request gone from the latch but done flag still set
        chk("lost request poll", 16'h0001, {15'h0000, (irq === 1'b0) && (rlo[5] === 1'b1)});
        chk("done poll", 16'h0001, {15'h0000, rlo[5]});
        rd = 1'b1;
        step(1);
        rd = 1'b0;
        step(1);
        chk("done read", 16'h0000, {15'h0000, rlo[5]});
        chk_result(10'h2B5);
    endtask

    task automatic standby_abort();
        int n;
        int seen;
        level = 10'h0F3;
        wr(1'b0, 8'hA3);
        step(50);
        standby = 1'b1;
        step(1);
        chk("sb ctl1", 16'h0000, {8'h00, ctl1});
        chk("sb ctl2", 16'h0000, {8'h00, ctl2});
        chk("sb result", 16'h0000, {rhi, rlo});
        chk("sb ref", 16'h0000, {15'h0000, ref_con});
        wr(1'b0, 8'hA3);
        chk("sb write", 16'h0000, {8'h00, ctl1});
        seen = 0;
        for (int i = 0; i < 800; i++)
        begin
            if (i == 400)
                standby = 1'b0;
            step(1);
            if (irq === 1'b1)
                seen++;
            if (i < 400 && ref_con !== 1'b0)
                seen++;
        end
        chk("no resume", 16'h0000, seen[15:0]);
        chk("idle busy", 16'h0000, {15'h0000, rlo[4]});
        wr(1'b1, 8'hD8);
        wr(1'b0, 8'hA3);
        wait_irq(n);
        chk_result(10'h0F3);
    endtask

    // shortest period in repeat mode, then stop by writing mode off
    task automatic repeat_stop();
        int n;
        level = 10'h3FF;
        wr(1'b1, 8'h10);
        wr(1'b0, 8'hE3);
        wait_irq(n);
        chk_result(10'h3FF);
        step(1);
        chk("rep busy", 16'h0001, {15'h0000, rlo[4]});
        level = 10'h001;
        wait_irq(n);
        chk("rep period", 16'h0001, {15'h0000, (n >= 37 && n <= 41)});
        chk_result(10'h001);
        // a stored aborted conversion would show this new level
        level = 10'h155;
        step(10);
        wr(1'b0, 8'h13);
        step(2);
        chk("stop busy", 16'h0000, {15'h0000, rlo[4]});
        chk("in dis", 16'h0001, {15'h0000, in_dis});
        step(60);
        chk_result(10'h001);
    endtask

    initial
    begin
        cyc = 0;
        n_fail = 0;
        num_checks = 0;
        reset_n = 1'b0;
        standby = 1'b0;
        rd = 1'b0;
        level = 10'h000;
        w1 = '{wr: 1'b0, data: 8'h00};
        w2 = '{wr: 1'b0, data: 8'h00};
        step(10);
        reset_n = 1'b1;
        step(1);
        chk("reset regs", 16'h0000, {ctl1, ctl2});
        chk("reset res", 16'h0000, {rhi, rlo});
        single_conv();
        standby_abort();
        repeat_stop();
        complete_run();
    end
endmodule

`default_nettype wire
